// File: hdl/dapho_probe.sv
// probe-side access-port option engine: attribute words, power/reset requests,
// halt/run sequencing, key and instruction-register shifts, address remap
// assumes pins arrive asynchronously; the link clock is sampled by clk_sys
//
// The register addresses and the plain strobed port are this design's own decisions.
`timescale 1ns/1ps
module dapho_probe #(
	parameter logic [3:0] IR_INSTR  = 4'h1,
	parameter logic [3:0] IR_EXPECT = 4'h1,
	parameter int         REMAP_N   = 16
) (
	input  wire logic        clk_sys,
	input  wire logic        rst,
	input  wire logic [8:0]  reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [31:0] reg_rdata,
	input  wire logic        tck_pin,
	input  wire logic        tdo_pin,
	input  wire logic        cpu_locked_pin,
	input  wire logic        cache_ready_pin,
	input  wire logic [1:0]  pwr_ack_pin,
	input  wire logic        ace_support_pin,
	input  wire logic [31:0] cpu_addr,
	output logic             jtag_tdi,
	output logic             jtag_shift,
	output logic [31:0]      csw_ahb,
	output logic [31:0]      csw_axi,
	output logic             csw_load,
	output logic             ace_enable,
	output logic [1:0]       dbg_pwr_req,
	output logic             ctrl_rst_req,
	output logic             reset_pin_out,
	output logic             halt_req,
	output logic             cti_stop,
	output logic             unlock_catch,
	output logic             lock_restore,
	output logic             cache_inval,
	output logic             run_req,
	output logic             step_req,
	output logic             cache_rd,
	output logic [31:0]      port_addr,
	output logic             remap_hit
);
	localparam logic [7:0] RST_CNT = 8'(dapho_pkg::RST_CYC);

	logic [dapho_pkg::SY_W-1:0]       meta_q, sync_q;
	logic                             tck_d_q;
	logic [dapho_pkg::AHB_PROT_W-1:0] ahb_prot_q, ahb_prot_d;
	logic [dapho_pkg::AXI_PROT_W-1:0] axi_prot_q, axi_prot_d;
	logic [dapho_pkg::ATTR_W-1:0]     attr_q, attr_d;
	logic [dapho_pkg::OPT_W-1:0]      opt_q;
	logic [31:0]                      key_q [dapho_pkg::KEY_N];
	logic [7:0]                       rcnt_q, rcnt_d;
	logic                             rmode_q, rmode_d;
	logic                             armed_q, lock_cached_q, cwait_q, run_pend_q, step_pend_q;
	logic                             ir_mode_q, ir_bad_q;
	dapho_pkg::dapho_state_t          state_q, state_d;
	logic [dapho_pkg::SHIFT_W-1:0]    sh_q, sh_d;
	logic [7:0]                       cnt_q, cnt_d;
	logic                             tdi_d, ir_bad_d, ir_mode_d;

	// pin synchronisers
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			meta_q  <= '0;
			sync_q  <= '0;
			tck_d_q <= 1'b0;
		end else begin
			meta_q  <= {ace_support_pin, pwr_ack_pin, cache_ready_pin, cpu_locked_pin, tdo_pin, tck_pin};
			sync_q  <= meta_q;
			tck_d_q <= sync_q[dapho_pkg::SY_TCK];
		end
	end

	wire tck_rise = sync_q[dapho_pkg::SY_TCK] & ~tck_d_q;
	wire tck_fall = ~sync_q[dapho_pkg::SY_TCK] & tck_d_q;
	wire locked   = sync_q[dapho_pkg::SY_LOCK];

	// register decode
	wire wr_ahb  = reg_wr && reg_addr == dapho_pkg::OFF_AHB_PROT;
	wire wr_axi  = reg_wr && reg_addr == dapho_pkg::OFF_AXI_PROT;
	wire wr_attr = reg_wr && reg_addr == dapho_pkg::OFF_AXI_ATTR;
	wire wr_opt  = reg_wr && reg_addr == dapho_pkg::OFF_OPTIONS;
	wire wr_key  = reg_wr && (reg_addr & ~dapho_pkg::KEY_MASK) == dapho_pkg::OFF_KEY0;
	wire [1:0] key_idx = reg_addr[dapho_pkg::KEY_IDX_LSB +: 2];
	wire wr_remap = reg_wr && reg_addr[dapho_pkg::REMAP_BIT];
	wire [dapho_pkg::CMD_W-1:0] cmd =
		(reg_wr && reg_addr == dapho_pkg::OFF_CMD) ? reg_wdata[dapho_pkg::CMD_W-1:0] : '0;

	wire opt_hwl    = opt_q[dapho_pkg::OPT_HWL];
	wire opt_poll   = opt_q[dapho_pkg::OPT_POLL];
	wire opt_inval  = opt_q[dapho_pkg::OPT_INVAL];
	wire opt_regrst = opt_q[dapho_pkg::OPT_REGRST];
	wire opt_skipir = opt_q[dapho_pkg::OPT_SKIPIR];
	wire dapho_pkg::dapho_pwr_t pol0 = dapho_pkg::dapho_pwr_t'(opt_q[dapho_pkg::OPT_PWR0 +: 2]);
	wire dapho_pkg::dapho_pwr_t pol1 = dapho_pkg::dapho_pwr_t'(opt_q[dapho_pkg::OPT_PWR1 +: 2]);

	function automatic logic pwr_next(input dapho_pkg::dapho_pwr_t pol, input logic cur,
	                                  input logic start, input logic stop);
		if (pol == dapho_pkg::PWR_OFF)
			pwr_next = 1'b0;                            // R15
		else if (start)
			pwr_next = 1'b1;                            // R13
		else if (stop)
			pwr_next = pol == dapho_pkg::PWR_KEEP_POWERED ? cur : 1'b0; // R14
		else
			pwr_next = cur;
	endfunction : pwr_next

	assign ahb_prot_d = wr_ahb ? reg_wdata[dapho_pkg::AHB_PROT_W-1:0] : ahb_prot_q;
	assign axi_prot_d = wr_axi ? reg_wdata[dapho_pkg::AXI_PROT_W-1:0] : axi_prot_q;
	assign attr_d     = wr_attr ? reg_wdata[dapho_pkg::ATTR_W-1:0] : attr_q;
	wire [5:0]  attr_cd   = dapho_pkg::attr_lookup(attr_d);
	wire [31:0] csw_ahb_d = 32'(ahb_prot_d) << dapho_pkg::AHB_PROT_LSB; // R1
	wire [31:0] csw_axi_d = (32'(axi_prot_d) << dapho_pkg::AXI_PROT_LSB)  // R6
	                      | (32'(attr_cd[5:2]) << dapho_pkg::CACHE_LSB)
	                      | (32'(attr_cd[1:0]) << dapho_pkg::DOMAIN_LSB);

	// halt, run and cache sequencing
	wire go_cmd     = cmd[dapho_pkg::CMD_RUN] | cmd[dapho_pkg::CMD_STEP];
	wire halt_lock  = cmd[dapho_pkg::CMD_HALT] & locked;
	wire halt_req_d = (cmd[dapho_pkg::CMD_HALT] | armed_q) & ~locked; // R7
	wire armed_d    = locked & (armed_q | (cmd[dapho_pkg::CMD_HALT] & ~opt_hwl)); // R7
	wire cache_want = cwait_q | cmd[dapho_pkg::CMD_CACHE];
	wire cache_rd_d = cache_want & (~opt_poll | sync_q[dapho_pkg::SY_READY]); // R9

	assign rmode_d = cmd[dapho_pkg::CMD_RESET] ? opt_regrst : rmode_q;
	assign rcnt_d  = cmd[dapho_pkg::CMD_RESET] ? RST_CNT : (rcnt_q != 8'h00 ? rcnt_q - 8'h01 : 8'h00);

	wire [31:0] status = {23'h0, cwait_q, armed_q, lock_cached_q,
	                      sync_q[dapho_pkg::SY_ACK1] & (pol1 != dapho_pkg::PWR_OFF),
	                      sync_q[dapho_pkg::SY_ACK0] & (pol0 != dapho_pkg::PWR_OFF),
	                      dbg_pwr_req, ir_bad_q, state_q != dapho_pkg::ST_IDLE};
	wire [31:0] rdata_d =
		reg_addr == dapho_pkg::OFF_AHB_PROT ? 32'(ahb_prot_q) :
		reg_addr == dapho_pkg::OFF_AXI_PROT ? 32'(axi_prot_q) :
		reg_addr == dapho_pkg::OFF_AXI_ATTR ? 32'(attr_q) :
		reg_addr == dapho_pkg::OFF_OPTIONS  ? 32'(opt_q) :
		(reg_addr & ~dapho_pkg::KEY_MASK) == dapho_pkg::OFF_KEY0 ? key_q[key_idx] :
		reg_addr == dapho_pkg::OFF_STATUS   ? status : 32'h0;

	// shift engine; commands arriving while busy are ignored
	always_comb begin
		state_d   = state_q;
		sh_d      = sh_q;
		cnt_d     = cnt_q;
		tdi_d     = jtag_tdi;
		ir_bad_d  = ir_bad_q;
		ir_mode_d = ir_mode_q;
		case (state_q)
			dapho_pkg::ST_IDLE: begin
				if (cmd[dapho_pkg::CMD_KEY]) begin
					sh_d      = {key_q[3], key_q[2], key_q[1], key_q[0]}; // R11
					cnt_d     = 8'(dapho_pkg::SHIFT_W);
					tdi_d     = key_q[0][0];
					ir_mode_d = 1'b0;
					state_d   = dapho_pkg::ST_SHIFT;
				end else if (cmd[dapho_pkg::CMD_IR]) begin
					sh_d      = {{(dapho_pkg::SHIFT_W - dapho_pkg::IR_W){1'b0}}, IR_INSTR};
					cnt_d     = 8'(dapho_pkg::IR_W);
					tdi_d     = IR_INSTR[0];
					ir_mode_d = 1'b1;
					state_d   = dapho_pkg::ST_SHIFT;
				end
			end
			dapho_pkg::ST_SHIFT: begin
				if (tck_rise) begin
					sh_d  = {sync_q[dapho_pkg::SY_TDO], sh_q[dapho_pkg::SHIFT_W-1:1]}; // R11
					cnt_d = cnt_q - 8'h01;
					if (cnt_q == 8'h01)
						state_d = dapho_pkg::ST_DONE;
				end else if (tck_fall) begin
					tdi_d = sh_q[0];
				end
			end
			dapho_pkg::ST_DONE: begin
				if (ir_mode_q)
					ir_bad_d = ~opt_skipir &&
						sh_q[dapho_pkg::SHIFT_W-1 -: dapho_pkg::IR_W] != IR_EXPECT; // R16
				state_d = dapho_pkg::ST_IDLE;
			end
			default: state_d = dapho_pkg::ST_IDLE;
		endcase
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			ahb_prot_q <= '0;
			axi_prot_q <= '0;
			attr_q     <= '0;
			opt_q      <= dapho_pkg::OPT_RST;
			for (int i = 0; i < dapho_pkg::KEY_N; i++)
				key_q[i] <= '0;
			reg_rdata  <= '0;
		end else begin
			ahb_prot_q <= ahb_prot_d;
			axi_prot_q <= axi_prot_d;
			attr_q     <= attr_d;
			if (wr_opt)
				opt_q <= reg_wdata[dapho_pkg::OPT_W-1:0];
			if (wr_key)
				key_q[key_idx] <= reg_wdata;
			reg_rdata  <= reg_rd ? rdata_d : 32'h0;
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			csw_ahb     <= '0;
			csw_axi     <= '0;
			csw_load    <= 1'b0;
			ace_enable  <= 1'b0;
			dbg_pwr_req <= '0;
		end else begin
			csw_ahb     <= csw_ahb_d;
			csw_axi     <= csw_axi_d;
			csw_load    <= wr_ahb | wr_axi | wr_attr | cmd[dapho_pkg::CMD_START]; // R19
			ace_enable  <= opt_q[dapho_pkg::OPT_ACE] & sync_q[dapho_pkg::SY_ACE]; // R2
			dbg_pwr_req <= {pwr_next(pol1, dbg_pwr_req[1], cmd[dapho_pkg::CMD_START], cmd[dapho_pkg::CMD_END]),
			                pwr_next(pol0, dbg_pwr_req[0], cmd[dapho_pkg::CMD_START], cmd[dapho_pkg::CMD_END])};
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			rcnt_q        <= '0;
			rmode_q       <= 1'b0;
			ctrl_rst_req  <= 1'b0;
			reset_pin_out <= 1'b0;
		end else begin
			rcnt_q        <= rcnt_d;
			rmode_q       <= rmode_d;
			ctrl_rst_req  <= rcnt_d != 8'h00 && rmode_d;  // R12
			reset_pin_out <= rcnt_d != 8'h00 && !rmode_d; // R12
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			armed_q       <= 1'b0;
			lock_cached_q <= 1'b0;
			halt_req      <= 1'b0;
			cti_stop      <= 1'b0;
			unlock_catch  <= 1'b0;
			lock_restore  <= 1'b0;
			cache_inval   <= 1'b0;
			run_pend_q    <= 1'b0;
			step_pend_q   <= 1'b0;
			run_req       <= 1'b0;
			step_req      <= 1'b0;
			cwait_q       <= 1'b0;
			cache_rd      <= 1'b0;
		end else begin
			armed_q       <= armed_d;
			unlock_catch  <= armed_d;
			halt_req      <= halt_req_d;
			cti_stop      <= halt_lock & opt_hwl;                            // R8
			lock_cached_q <= (halt_lock & opt_hwl) | (lock_cached_q & ~(run_pend_q | step_pend_q)); // R8
			lock_restore  <= (run_pend_q | step_pend_q) & lock_cached_q;    // R8
			cache_inval   <= go_cmd & opt_inval;                            // R10
			run_pend_q    <= cmd[dapho_pkg::CMD_RUN];
			step_pend_q   <= cmd[dapho_pkg::CMD_STEP];
			run_req       <= run_pend_q;
			step_req      <= step_pend_q;
			cwait_q       <= cache_want & ~cache_rd_d;
			cache_rd      <= cache_rd_d;
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			state_q    <= dapho_pkg::ST_IDLE;
			sh_q       <= '0;
			cnt_q      <= '0;
			jtag_tdi   <= 1'b0;
			jtag_shift <= 1'b0;
			ir_bad_q   <= 1'b0;
			ir_mode_q  <= 1'b0;
		end else begin
			state_q    <= state_d;
			sh_q       <= sh_d;
			cnt_q      <= cnt_d;
			jtag_tdi   <= tdi_d;
			jtag_shift <= state_d == dapho_pkg::ST_SHIFT;
			ir_bad_q   <= ir_bad_d;
			ir_mode_q  <= ir_mode_d;
		end
	end

	dapho_remap #(
		.N  (REMAP_N),
		.AW (32)
	) u_remap (
		.clk_sys       (clk_sys),
		.rst           (rst),
		.cfg_wr        (wr_remap),
		.cfg_idx       (reg_addr[dapho_pkg::REMAP_IDX_LSB +: 4]),
		.cfg_field     (reg_addr[dapho_pkg::REMAP_FLD_LSB +: 2]),
		.cfg_wdata     (reg_wdata),
		.lookup_addr   (cpu_addr),
		.mapped_addr_q (port_addr),
		.hit_q         (remap_hit)
	);

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);

	property p_ahb_word;
		csw_load |-> csw_ahb[dapho_pkg::AHB_PROT_LSB +: dapho_pkg::AHB_PROT_W] == ahb_prot_q;
	endproperty
	a_ahb_word: assert property (p_ahb_word) else $error("ahb control word protection mismatch"); // R1
	property p_pwr_start;
		cmd[dapho_pkg::CMD_START] && pol0 != dapho_pkg::PWR_OFF |=> dbg_pwr_req[0];
	endproperty
	a_pwr_start: assert property (p_pwr_start) else $error("power not requested at start"); // R13
	property p_pwr_keep;
		cmd[dapho_pkg::CMD_END] && !cmd[dapho_pkg::CMD_START] && pol0 == dapho_pkg::PWR_KEEP_POWERED
			&& dbg_pwr_req[0] |=> dbg_pwr_req[0];
	endproperty
	a_pwr_keep: assert property (p_pwr_keep) else $error("kept power was released"); // R14
	property p_pwr_off;
		pol1 == dapho_pkg::PWR_OFF |=> !dbg_pwr_req[1];
	endproperty
	a_pwr_off: assert property (p_pwr_off) else $error("power requested under off policy"); // R15
	sequence s_inval_then_go;
		cache_inval ##1 (run_req | step_req);
	endsequence
	property p_inval;
		go_cmd && opt_inval |=> s_inval_then_go;
	endproperty
	a_inval: assert property (p_inval) else $error("no invalidate before run or step"); // R10
	property p_locked_run;
		halt_lock && !opt_hwl |=> unlock_catch && !cti_stop && !halt_req;
	endproperty
	a_locked_run: assert property (p_locked_run) else $error("locked cpu not left running"); // R7
	property p_locked_stop;
		halt_lock && opt_hwl |=> cti_stop && lock_cached_q;
	endproperty
	a_locked_stop: assert property (p_locked_stop) else $error("locked cpu not stopped"); // R8
	property p_cache_poll;
		cache_rd && opt_poll |-> $past(sync_q[dapho_pkg::SY_READY]);
	endproperty
	a_cache_poll: assert property (p_cache_poll) else $error("cache read before ready"); // R9
	property p_reg_reset;
		cmd[dapho_pkg::CMD_RESET] && opt_regrst |=> (ctrl_rst_req && !reset_pin_out) [*2];
	endproperty
	a_reg_reset: assert property (p_reg_reset) else $error("register reset used reset pin"); // R12
	property p_key_first;
		state_q == dapho_pkg::ST_IDLE && cmd[dapho_pkg::CMD_KEY] |=> jtag_shift && jtag_tdi == key_q[0][0];
	endproperty
	a_key_first: assert property (p_key_first) else $error("key shift did not start with key0 lsb"); // R11
endmodule : dapho_probe

// File: hdl/dapho_pkg.sv
// constants, encodings and register map of the probe-side access-port option block
// assumes a 40 MHz system clock and a single plain register port
// Behaviour
// R1 - AHB port control word carries a software protection value, zero after reset.
// R2 - coherent enable issues coherent transactions only when the target supports them.
// R3 - device attribute codes map to cache/domain pairs 0/0, 1/1, 1/2, 1/3.
// R4 - non-cacheable codes map to 2/0, 3/1, 3/2, 3/3.
// R5 - cacheable codes map to 6/0, a/1, e/2, e/3.
// R6 - AXI port control word carries its own protection value, zero after reset.
// R7 - halting a locked cpu without permission arms unlock catch, cpu keeps running.
// R8 - with permission, a locked cpu halts via cross-trigger; lock restored on run/step.
// R9 - with polling on, each cache item read waits for the cpu ready flag.
// R10 - with invalidation on (default), cache invalidates before each run and step.
// R11 - four 32-bit keys shift as one 128-bit shift, key0 first, LSB first.
// R12 - register reset option resets cpu by control-word reset bit, not reset pin.
// R13 - default policy sets debug power request at session start, clears at end.
// R14 - keep-powered policy requests power at start and never releases it.
// R15 - off policy never requests or checks power; request bit stays zero.
// R16 - skip option suppresses comparing the returned instruction-register pattern.
// R17 - sixteen remap entries translate an address range onto one base address.
// R18 - the target port applies the written attributes to its bus transactions.
// R19 - attribute words are loaded at session start and whenever selection changes.
package dapho_pkg;
	localparam int          ADDR_W        = 9;
	localparam int          DATA_W        = 32;
	localparam logic [8:0]  OFF_AHB_PROT  = 9'h000;
	localparam logic [8:0]  OFF_AXI_PROT  = 9'h004;
	localparam logic [8:0]  OFF_AXI_ATTR  = 9'h008;
	localparam logic [8:0]  OFF_OPTIONS   = 9'h00c;
	localparam logic [8:0]  OFF_KEY0      = 9'h010;
	localparam logic [8:0]  KEY_MASK      = 9'h00c;
	localparam int          KEY_IDX_LSB   = 2;
	localparam logic [8:0]  OFF_CMD       = 9'h020;
	localparam logic [8:0]  OFF_STATUS    = 9'h024;
	localparam int          REMAP_BIT     = 8;
	localparam int          REMAP_IDX_LSB = 4;
	localparam int          REMAP_FLD_LSB = 2;
	// option bits
	localparam int          OPT_HWL       = 0;
	localparam int          OPT_POLL      = 1;
	localparam int          OPT_INVAL     = 2;
	localparam int          OPT_REGRST    = 3;
	localparam int          OPT_SKIPIR    = 4;
	localparam int          OPT_PWR0      = 5;
	localparam int          OPT_PWR1      = 7;
	localparam int          OPT_ACE       = 9;
	localparam int          OPT_W         = 10;
	localparam logic [9:0]  OPT_RST       = 10'h004;
	// command bits
	localparam int          CMD_START     = 0;
	localparam int          CMD_END       = 1;
	localparam int          CMD_HALT      = 2;
	localparam int          CMD_RUN       = 3;
	localparam int          CMD_STEP      = 4;
	localparam int          CMD_KEY       = 5;
	localparam int          CMD_IR        = 6;
	localparam int          CMD_RESET     = 7;
	localparam int          CMD_CACHE     = 8;
	localparam int          CMD_W         = 9;
	// sync vector positions
	localparam int          SY_TCK        = 0;
	localparam int          SY_TDO        = 1;
	localparam int          SY_LOCK       = 2;
	localparam int          SY_READY      = 3;
	localparam int          SY_ACK0       = 4;
	localparam int          SY_ACK1       = 5;
	localparam int          SY_ACE        = 6;
	localparam int          SY_W          = 7;
	// control word layout
	localparam int          AHB_PROT_W    = 7;
	localparam int          AHB_PROT_LSB  = 24;
	localparam int          AXI_PROT_W    = 3;
	localparam int          AXI_PROT_LSB  = 28;
	localparam int          CACHE_LSB     = 24;
	localparam int          DOMAIN_LSB    = 13;
	localparam int          ATTR_W        = 4;
	// shift
	localparam int          KEY_N         = 4;
	localparam int          KEY_W         = 32;
	localparam int          SHIFT_W       = 128;
	localparam int          IR_W          = 4;
	localparam int          CNT_W         = 8;
	// reset request pulse
	localparam int          CLK_NS        = 25;
	localparam int          RST_PULSE_NS  = 1000;
	localparam int          RST_CYC       = (RST_PULSE_NS + CLK_NS - 1) / CLK_NS;

	typedef enum logic [1:0] {
		PWR_ON           = 2'h0,
		PWR_KEEP_POWERED = 2'h1,
		PWR_OFF          = 2'h2
	} dapho_pwr_t;

	typedef enum logic [2:0] {
		ST_IDLE  = 3'b001,
		ST_SHIFT = 3'b010,
		ST_DONE  = 3'b100
	} dapho_state_t;

	// returns {cache[3:0], domain[1:0]}
	function automatic logic [5:0] attr_lookup(input logic [3:0] code);
		case (code)
			4'h0: attr_lookup = {4'h0, 2'h0};   // R3
			4'h1: attr_lookup = {4'h1, 2'h1};   // R3
			4'h2: attr_lookup = {4'h1, 2'h2};   // R3
			4'h3: attr_lookup = {4'h1, 2'h3};   // R3
			4'h4: attr_lookup = {4'h2, 2'h0};   // R4
			4'h5: attr_lookup = {4'h3, 2'h1};   // R4
			4'h6: attr_lookup = {4'h3, 2'h2};   // R4
			4'h7: attr_lookup = {4'h3, 2'h3};   // R4
			4'h8: attr_lookup = {4'h6, 2'h0};   // R5
			4'h9: attr_lookup = {4'ha, 2'h1};   // R5
			4'ha: attr_lookup = {4'he, 2'h2};   // R5
			4'hb: attr_lookup = {4'he, 2'h3};   // R5
			default: attr_lookup = {4'h0, 2'h0};
		endcase
	endfunction : attr_lookup
endpackage : dapho_pkg

// File: hdl/dapho_remap.sv
// remap table: translates cpu-view addresses into access-port-view addresses
// assumes configuration writes come from the same clock domain
`timescale 1ns/1ps
module dapho_remap #(
	parameter int N  = 16,
	parameter int AW = 32
) (
	input  wire logic                 clk_sys,
	input  wire logic                 rst,
	input  wire logic                 cfg_wr,
	input  wire logic [$clog2(N)-1:0] cfg_idx,
	input  wire logic [1:0]           cfg_field,
	input  wire logic [AW-1:0]        cfg_wdata,
	input  wire logic [AW-1:0]        lookup_addr,
	output logic      [AW-1:0]        mapped_addr_q,
	output logic                      hit_q
);
	logic [AW-1:0] base_q   [N];
	logic [AW-1:0] limit_q  [N];
	logic [AW-1:0] target_q [N];
	logic [N-1:0]  en_q;
	logic [AW-1:0] mapped_d;
	logic          hit_d;

	// lowest matching index wins
	always_comb begin
		mapped_d = lookup_addr;
		hit_d    = 1'b0;
		for (int i = N - 1; i >= 0; i--) begin
			if (en_q[i] && lookup_addr >= base_q[i] && lookup_addr <= limit_q[i]) begin
				mapped_d = target_q[i] + (lookup_addr - base_q[i]); // R17
				hit_d    = 1'b1;
			end
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			for (int i = 0; i < N; i++) begin
				base_q[i]   <= '0;
				limit_q[i]  <= '0;
				target_q[i] <= '0;
			end
			en_q          <= '0;
			mapped_addr_q <= '0;
			hit_q         <= 1'b0;
		end else begin
			if (cfg_wr) begin
				case (cfg_field)
					2'h0: base_q[cfg_idx]   <= cfg_wdata;
					2'h1: limit_q[cfg_idx]  <= cfg_wdata;
					2'h2: target_q[cfg_idx] <= cfg_wdata;
					default: en_q[cfg_idx]  <= cfg_wdata[0];
				endcase
			end
			mapped_addr_q <= mapped_d;
			hit_q         <= hit_d;
		end
	end
endmodule : dapho_remap

// File: verification/dapho_far.sv
// far-side model of the access port link: clocks tck only while a shift runs
// assumes the probe drives tdi within three sampling cycles of a tck fall
`timescale 1ns/1ps
module dapho_far (
	input  wire logic        jtag_shift,
	input  wire logic        jtag_tdi,
	input  wire logic [31:0] csw_axi,
	input  wire logic        csw_load,
	output logic             tck_pin,
	output logic             tdo_pin
);
	logic        got[$];
	logic [31:0] applied = '0;
	// the access port takes the control word a moment after each load pulse
	always @(posedge csw_load) #1 applied = csw_axi;
	initial begin
		tck_pin = 1'b0;
		tdo_pin = 1'b0;
		forever begin
			#100;
			if (jtag_shift) begin
				tck_pin = 1'b1;
				// returned bit is the inverse of the bit taken
				tdo_pin = ~jtag_tdi;
				got.push_back(jtag_tdi);
				#100;
				tck_pin = 1'b0;
			end else
				// released data line toggles so a stale value never looks valid
				tdo_pin = ~tdo_pin;
		end
	end
endmodule : dapho_far

// File: verification/dapho_probe_tb.sv
// self-checking bench of the access-port option engine with a link model
// assumes outputs registered on the taking edge; run and step requests one cycle later
`timescale 1ns/1ps
module dapho_probe_tb;
	logic        clk_sys = 1'b0;
	logic        rst = 1'b1;
	logic [8:0]  reg_addr = '0;
	logic [31:0] reg_wdata = '0;
	logic        reg_wr = 1'b0;
	logic        reg_rd = 1'b0;
	logic        lock = 1'b0;
	logic        rdy = 1'b0;
	logic [1:0]  ack = '0;
	logic        ace = 1'b0;
	logic [31:0] cpu_addr = '0;
	logic [31:0] reg_rdata, csw_ahb, csw_axi, port_addr;
	logic [1:0]  dbg_pwr_req;
	logic        tck, tdo, tdi, shift, csw_load, ctrl_rst_req, reset_pin_out;
	logic        halt_req, cti_stop, unlock_catch, lock_restore, cache_inval, run_req;
	logic        ace_en, step_req, cache_rd, remap_hit;
	int          miscompares = 0;
	int          check_count = 0;
	int          seed = 42;
	int          cyc = 0;
	int          cache_tab[12] = '{0, 1, 1, 1, 2, 3, 3, 3, 6, 10, 14, 14};
	bit          exp_q[$];
	logic [31:0] r;
	dapho_probe uut (.clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .tck_pin(tck), .tdo_pin(tdo), .cpu_locked_pin(lock),
		.cache_ready_pin(rdy), .pwr_ack_pin(ack), .ace_support_pin(ace), .cpu_addr(cpu_addr), .jtag_tdi(tdi),
		.jtag_shift(shift), .csw_ahb(csw_ahb), .csw_axi(csw_axi), .csw_load(csw_load), .ace_enable(ace_en),
		.dbg_pwr_req(dbg_pwr_req), .ctrl_rst_req(ctrl_rst_req), .reset_pin_out(reset_pin_out),
		.halt_req(halt_req), .cti_stop(cti_stop), .unlock_catch(unlock_catch), .lock_restore(lock_restore),
		.cache_inval(cache_inval), .run_req(run_req), .step_req(step_req), .cache_rd(cache_rd),
		.port_addr(port_addr), .remap_hit(remap_hit));
	dapho_far far (.jtag_shift(shift), .jtag_tdi(tdi), .tck_pin(tck), .tdo_pin(tdo), .csw_axi(csw_axi),
		.csw_load(csw_load));
	initial begin
		forever #12.5 clk_sys = ~clk_sys;
	end
	task automatic test_done;
		$display("checks %0d errors %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : test_done
	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			miscompares++;
			test_done();
		end
	end
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		check_count++;
		if (g !== e) begin
			miscompares++;
			$display("Error %s exp %h got %h", n, e, g);
		end
	endtask : chk
	// both tasks return just past the taking edge, in the answer cycle
	task automatic wr(input logic [8:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
		#1;
	endtask : wr
	task automatic rd(input logic [8:0] a, input logic [31:0] e);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1;
		chk("rdata", e, reg_rdata);
	endtask : rd
	task automatic cyc_n(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask : cyc_n
	initial begin
		cyc_n(2);
		rst <= 1'b0;
		cpu_addr <= $random(seed);
		rd(dapho_pkg::OFF_OPTIONS, 32'h0000_0004);
		rd(9'h030, 32'h0);
		chk("pass addr", cpu_addr, port_addr);
		chk("no hit", 0, remap_hit);
		chk("ahb", 32'h0, csw_ahb);
		chk("axi", 32'h0, csw_axi);
		r = $random(seed);
		wr(dapho_pkg::OFF_AHB_PROT, {25'h0, r[6:0]});
		wr(dapho_pkg::OFF_AXI_PROT, {29'h0, r[10:8]});
		cyc_n(1);
		chk("ahb prot", r[6:0], csw_ahb[30:24]);
		chk("axi prot", r[10:8], csw_axi[30:28]);
		for (int i = 0; i < 12; i++) begin
			wr(dapho_pkg::OFF_AXI_ATTR, i);
			chk("load", 1, csw_load);
			cyc_n(1);
			chk("cache", cache_tab[i], csw_axi[27:24]);
			chk("domain", i % 4, csw_axi[14:13]);
			chk("applied", cache_tab[i], far.applied[27:24]);
		end
		foreach (cache_tab[k]) begin
			if (k < 3) begin
				r = (k + 2) % 3;
				wr(dapho_pkg::OFF_OPTIONS, 32'h4 | (r << 5) | (r << 7));
				wr(dapho_pkg::OFF_CMD, 32'h1);
				chk("pwr start", (r == 2) ? 0 : 3, dbg_pwr_req);
				wr(dapho_pkg::OFF_CMD, 32'h2);
				chk("pwr end", (r == 1) ? 3 : 0, dbg_pwr_req);
			end
		end
		lock <= 1'b1;
		wr(dapho_pkg::OFF_OPTIONS, 32'h4);
		cyc_n(4);
		wr(dapho_pkg::OFF_CMD, 32'h1 << dapho_pkg::CMD_HALT);
		chk("catch", 1, unlock_catch);
		chk("halt", 0, halt_req);
		lock <= 1'b0;
		r = 0;
		for (int i = 0; i < 8; i++) begin
			cyc_n(1);
			r = r | halt_req;
		end
		chk("halt later", 1, r);
		lock <= 1'b1;
		wr(dapho_pkg::OFF_OPTIONS, 32'h5);
		cyc_n(4);
		wr(dapho_pkg::OFF_CMD, 32'h1 << dapho_pkg::CMD_HALT);
		chk("stop", 1, cti_stop);
		wr(dapho_pkg::OFF_CMD, 32'h1 << dapho_pkg::CMD_RUN);
		chk("inval", 1, cache_inval);
		cyc_n(1);
		chk("run", 1, run_req);
		chk("restore", 1, lock_restore);
		wr(dapho_pkg::OFF_OPTIONS, 32'hc);
		wr(dapho_pkg::OFF_CMD, 32'h1 << dapho_pkg::CMD_RESET);
		chk("reg rst", 1, ctrl_rst_req);
		chk("pin rst", 0, reset_pin_out);
		ace <= 1'b1;
		wr(dapho_pkg::OFF_OPTIONS, 32'h206);
		cyc_n(3);
		chk("ace", 1, ace_en);
		ace <= 1'b0;
		wr(dapho_pkg::OFF_CMD, 32'h1 << dapho_pkg::CMD_CACHE);
		chk("cache wait", 0, cache_rd);
		rdy <= 1'b1;
		r = 0;
		for (int i = 0; i < 8; i++) begin
			cyc_n(1);
			r = r | cache_rd;
		end
		chk("cache rd", 1, r);
		chk("ace off", 0, ace_en);
		wr(dapho_pkg::OFF_CMD, 32'h1 << dapho_pkg::CMD_STEP);
		chk("inval", 1, cache_inval);
		cyc_n(1);
		chk("step", 1, step_req);
		r = $random(seed) & 32'hffff_f000;
		wr(9'h100, cpu_addr & 32'hffff_f000);
		wr(9'h104, cpu_addr | 32'h0000_0fff);
		wr(9'h108, r);
		wr(9'h10c, 32'h1);
		cyc_n(1);
		chk("remap addr", r | (cpu_addr & 32'h0000_0fff), port_addr);
		chk("remap hit", 1, remap_hit);
		for (int k = 0; k < 4; k++) begin
			r = $random(seed);
			wr(dapho_pkg::OFF_KEY0 + 4 * k, r);
			for (int b = 0; b < 32; b++) exp_q.push_back(r[b]);
		end
		wr(dapho_pkg::OFF_CMD, 32'h1 << dapho_pkg::CMD_KEY);
		for (int i = 0; i < 1500 && shift === 1'b1; i++) cyc_n(1);
		chk("key bits", 128, far.got.size());
		foreach (exp_q[i]) chk("key bit", exp_q[i], far.got[i]);
		// far side returns the inverted instruction, so only the skip option hides the mismatch
		for (int s = 0; s < 2; s++) begin
			wr(dapho_pkg::OFF_OPTIONS, 32'hc | (s << 4));
			wr(dapho_pkg::OFF_CMD, 32'h1 << dapho_pkg::CMD_IR);
			for (int i = 0; i < 200 && shift === 1'b1; i++) cyc_n(1);
			rd(dapho_pkg::OFF_STATUS, 32'hc | ((1 - s) << 1));
		end
		test_done();
	end
endmodule : dapho_probe_tb
